// ---- hdl/dps_top.v ----
`timescale 1ns/1ns
`include "dps_regs.vh"
// dual profile frame sequencer with apb register file
module dps_top
(
  input  wire        clk,
  input  wire        srst,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg         pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire        trig_in,
  input  wire        lnk_clk,
  output reg         frame_valid,
  output reg         line_valid,
  output reg         frame_prof,
  output reg         glob_rst,
  output reg         row_rst_stb,
  output reg  [11:0] row_rst_idx,
  output reg         row_rd_stb,
  output reg  [11:0] row_rd_idx,
  output reg  [31:0] prof_misc,
  output wire        adc12,
  output wire        shutter_global,
  output wire [2:0]  taps_code,
  output wire [1:0]  depth_code
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_EXP  = 4'b0010;
  localparam [3:0] ST_READ = 4'b0100;
  localparam [3:0] ST_PAD  = 4'b1000;

  reg  [15:0] ctrl_q;
  reg  [15:0] counts_q;
  reg  [15:0] rowpix_q;
  reg  [11:0] lines_q;
  reg  [31:0] prof_q [0:7];
  reg         rej_q;
  reg  [3:0]  st_q;
  reg         cur_prof_q;
  reg  [8:0]  seq_cnt_q;
  reg         phase_q;
  reg         burst_act_q;
  reg  [8:0]  ins_left_q;
  reg         trig_pend_q;
  reg  [4:0]  us_div_q;
  reg  [19:0] us_q;
  reg  [19:0] cur_expo_q;
  reg  [19:0] cur_per_q;
  reg  [15:0] cur_line_q;
  reg  [15:0] tick_q;
  reg  [9:0]  cyc_q;
  reg  [11:0] row_q;
  reg         line_open_q;

  wire [1:0]  in_lvl;
  wire [1:0]  in_rise;
  wire [1:0]  in_fall;
  wire [1:0]  pins = {lnk_clk, trig_in};

  // synchronise trigger pin and link clock pin
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_sync
      dps_sync u_sync
      (
        .clk    (clk),
        .srst   (srst),
        .ce     (ce),
        .din    (pins[gi]),
        .lvl_q  (in_lvl[gi]),
        .rise_q (in_rise[gi]),
        .fall_q (in_fall[gi])
      );
    end
  endgenerate

  wire        trig_edge = ctrl_q[`DPS_C_FALL] ? in_fall[0] : in_rise[0];
  wire        lnk_tick  = in_rise[1];
  wire [1:0]  tmode     = ctrl_q[`DPS_C_TMODE_HI:`DPS_C_TMODE_LO];
  wire        trig_en   = ctrl_q[`DPS_C_TRIG_EN];
  wire        auto_en   = ctrl_q[`DPS_C_AUTO];
  wire [8:0]  m_cnt     = {1'b0, counts_q[7:0]};
  wire [8:0]  n_cnt     = {1'b0, counts_q[15:8]};

  assign adc12          = ctrl_q[`DPS_C_ADC12];
  assign shutter_global = ctrl_q[`DPS_C_GLOBAL];
  assign taps_code      = ctrl_q[`DPS_C_TAPS_HI:`DPS_C_TAPS_LO];
  assign depth_code     = ctrl_q[`DPS_C_DEPTH_HI:`DPS_C_DEPTH_LO];

  // legality of a proposed control word
  function cfg_ok;
    input [15:0] c;
    reg   [2:0]  t;
    reg   [1:0]  d;
    begin
      t = c[`DPS_C_TAPS_HI:`DPS_C_TAPS_LO];
      d = c[`DPS_C_DEPTH_HI:`DPS_C_DEPTH_LO];
      cfg_ok = (t <= `DPS_TAP10) && (d <= `DPS_D12)
               && !((t == `DPS_TAP8) && (d == `DPS_D12))
               && !((t == `DPS_TAP10) && (d != `DPS_D8));
    end
  endfunction

  // apb decode
  wire        acc      = psel && penable;
  wire        is_prof  = (paddr[7:5] == `DPS_PROF_BASE) && (paddr[1:0] == 2'b00);
  wire [2:0]  pidx     = {paddr[4], paddr[3:2]};
  wire        is_known = is_prof || (paddr == `DPS_OFS_CTRL) || (paddr == `DPS_OFS_COUNTS)
                         || (paddr == `DPS_OFS_ROWPIX) || (paddr == `DPS_OFS_LINES)
                         || (paddr == `DPS_OFS_STATUS);
  wire        bad_ctrl = pwrite && (paddr == `DPS_OFS_CTRL) && !cfg_ok(pwdata[15:0]);
  wire        wr_go    = acc && pready && pwrite;

  // read mux
  reg  [31:0] rd_d;
  always @*
  begin
    rd_d = 32'h00000000;
    if (is_prof)
      rd_d = prof_q[pidx];
    else
      case (paddr)
        `DPS_OFS_CTRL:   rd_d = {16'h0000, ctrl_q};
        `DPS_OFS_COUNTS: rd_d = {16'h0000, counts_q};
        `DPS_OFS_ROWPIX: rd_d = {16'h0000, rowpix_q};
        `DPS_OFS_LINES:  rd_d = {20'h00000, lines_q};
        `DPS_OFS_STATUS: rd_d = {8'h00, ins_left_q, 2'b00, seq_cnt_q[7:0],
                                 rej_q, trig_pend_q, burst_act_q, cur_prof_q, st_q[0] == 1'b0};
        default:         rd_d = 32'h00000000;
      endcase
  end

  // apb handshake, one wait state
  always @(posedge clk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready  <= acc && !pready;
      if (acc && !pready)
      begin
        prdata  <= pwrite ? 32'h00000000 : rd_d;
        pslverr <= !is_known || bad_ctrl;
      end
    end
  end

  // register writes; profile block holds both profiles' settings
  integer k;
  always @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_q   <= `DPS_RST_CTRL;
      counts_q <= `DPS_RST_COUNTS;
      rowpix_q <= `DPS_RST_ROWPIX;
      lines_q  <= `DPS_RST_LINES;
      rej_q    <= 1'b0;
      for (k = 0; k < 8; k = k + 1)
        prof_q[k] <= `DPS_RST_PROF;
    end
    else if (ce && wr_go)
    begin
      if (is_prof)
        prof_q[pidx] <= pwdata;
      case (paddr)
        `DPS_OFS_CTRL:
        begin
          rej_q <= bad_ctrl;
          if (!bad_ctrl)
            ctrl_q <= pwdata[15:0];
        end
        `DPS_OFS_COUNTS: counts_q <= pwdata[15:0];
        `DPS_OFS_ROWPIX: rowpix_q <= pwdata[15:0];
        `DPS_OFS_LINES:  lines_q  <= pwdata[11:0];
        default:         rej_q    <= rej_q;
      endcase
    end
  end

  // choice of the next frame's profile, made only in idle
  reg         go;
  reg         nprof;
  reg         take;
  reg         nphase;
  reg  [8:0]  ncnt;
  reg         nburst;
  reg  [8:0]  nins;
  always @*
  begin
    go     = 1'b0;
    nprof  = ctrl_q[`DPS_C_MSEL];
    take   = 1'b0;
    nphase = phase_q;
    ncnt   = seq_cnt_q;
    nburst = burst_act_q;
    nins   = ins_left_q;
    if (!trig_en)
    begin
      go = 1'b1;
      if (auto_en)
        nprof = phase_q;
    end
    else
      case (tmode)
        `DPS_TM_SINGLE:
        begin
          go   = trig_pend_q;
          take = trig_pend_q;
        end
        `DPS_TM_BURST:
        begin
          nprof = burst_act_q ? phase_q : 1'b0;
          go    = burst_act_q || trig_pend_q;
          take  = !burst_act_q && trig_pend_q;
          if (take)
          begin
            nburst = 1'b1;
            nphase = 1'b0;
            ncnt   = 9'h000;
          end
        end
        `DPS_TM_INSERT:
        begin
          go = 1'b1;
          if (ins_left_q != 9'h000)
          begin
            nprof = 1'b1;
            nins  = ins_left_q - 9'h001;
          end
          else if (trig_pend_q)
          begin
            take  = 1'b1;
            nprof = 1'b1;
            nins  = n_cnt;
          end
          else
            nprof = 1'b0;
        end
        default: go = 1'b0;
      endcase
    // step the M/N counter for frames issued in the sequenced modes
    if ((!trig_en && auto_en) || (trig_en && (tmode == `DPS_TM_BURST) && (burst_act_q || take)))
    begin
      if (!nphase && (ncnt >= m_cnt))
      begin
        nphase = 1'b1;
        ncnt   = 9'h000;
      end
      else if (nphase && (ncnt >= n_cnt))
      begin
        nphase = 1'b0;
        ncnt   = 9'h000;
        nburst = 1'b0;
      end
      else
        ncnt = ncnt + 9'h001;
    end
  end

  // effective line time: chosen profile's, first profile's in alternating modes
  wire        alt    = (!trig_en && auto_en) || (trig_en && (tmode != `DPS_TM_SINGLE));
  wire        lprof  = alt ? 1'b0 : nprof;
  wire [15:0] prog_l = prof_q[{lprof, `DPS_PW_LINE}][15:0];
  reg  [15:0] min_l;
  always @*
  begin
    case (taps_code)
      `DPS_TAP1:  min_l = rowpix_q;
      `DPS_TAP2:  min_l = {1'b0, rowpix_q[15:1]};
      `DPS_TAP4:  min_l = {2'b00, rowpix_q[15:2]};
      `DPS_TAP8:  min_l = {3'b000, rowpix_q[15:3]};
      default:    min_l = rowpix_q / 16'd10;
    endcase
  end
  wire [15:0] eff_l  = (prog_l > min_l) ? prog_l : min_l;
  // timing counts at full width, cut on purpose where used
  localparam [31:0] FLOOR12 = `DPS_ADC12_US * `DPS_US_CYC;
  localparam [31:0] FLOOR10 = `DPS_ADC10_US * `DPS_US_CYC;
  localparam [31:0] US_LAST = `DPS_US_CYC - 1;
  localparam [31:0] FMAX    = `DPS_FRAME_MAX_US;
  wire [9:0]  floor_c = adc12 ? FLOOR12[9:0] : FLOOR10[9:0];
  wire        us_tick = (us_div_q == US_LAST[4:0]);
  wire        line_end = line_open_q && (tick_q >= cur_line_q) && (cyc_q >= floor_c);
  wire [11:0] rst_row  = row_q + cur_expo_q[11:0];

  // frame engine
  always @(posedge clk)
  begin
    if (srst)
    begin
      st_q        <= ST_IDLE;
      cur_prof_q  <= 1'b0;
      seq_cnt_q   <= 9'h000;
      phase_q     <= 1'b0;
      burst_act_q <= 1'b0;
      ins_left_q  <= 9'h000;
      trig_pend_q <= 1'b0;
      us_div_q    <= 5'h00;
      us_q        <= 20'h00000;
      cur_expo_q  <= 20'h00000;
      cur_per_q   <= 20'h00000;
      cur_line_q  <= 16'h0000;
      tick_q      <= 16'h0000;
      cyc_q       <= 10'h000;
      row_q       <= 12'h000;
      line_open_q <= 1'b0;
      frame_valid <= 1'b0;
      line_valid  <= 1'b0;
      frame_prof  <= 1'b0;
      glob_rst    <= 1'b0;
      row_rst_stb <= 1'b0;
      row_rst_idx <= 12'h000;
      row_rd_stb  <= 1'b0;
      row_rd_idx  <= 12'h000;
      prof_misc   <= 32'h00000000;
    end
    else if (ce)
    begin
      glob_rst    <= 1'b0;
      row_rst_stb <= 1'b0;
      row_rd_stb  <= 1'b0;
      // pending trigger: a new edge beats consumption
      trig_pend_q <= (trig_en && trig_edge) || (trig_pend_q && !take && trig_en) ||
                     (trig_en && trig_edge);
      if (!(st_q == ST_IDLE && ctrl_q[`DPS_C_RUN] && go))
        trig_pend_q <= (trig_en && trig_edge) || (trig_pend_q && trig_en);
      // microsecond timebase for exposure and frame period
      us_div_q <= us_tick ? 5'h00 : us_div_q + 5'h01;
      if (us_tick && (us_q != 20'hFFFFF))
        us_q <= us_q + 20'h00001;
      if (lnk_tick && (tick_q != 16'hFFFF))
        tick_q <= tick_q + 16'h0001;
      if (cyc_q != 10'h3FF)
        cyc_q <= cyc_q + 10'h001;
      case (st_q)
        ST_IDLE:
        begin
          frame_valid <= 1'b0;
          line_valid  <= 1'b0;
          if (ctrl_q[`DPS_C_RUN] && go)
          begin
            // settings latched here hold for the whole frame
            cur_prof_q  <= nprof;
            frame_prof  <= nprof;
            cur_expo_q  <= prof_q[{nprof, `DPS_PW_EXPO}][19:0];
            cur_per_q   <= prof_q[{nprof, `DPS_PW_PERIOD}][19:0];
            cur_line_q  <= eff_l;
            prof_misc   <= prof_q[{nprof, `DPS_PW_MISC}];
            phase_q     <= nphase;
            seq_cnt_q   <= ncnt;
            burst_act_q <= nburst;
            ins_left_q  <= nins;
            us_q        <= 20'h00000;
            us_div_q    <= 5'h00;
            row_q       <= 12'h000;
            line_open_q <= 1'b0;
            if (shutter_global)
            begin
              glob_rst <= 1'b1;
              st_q     <= ST_EXP;
            end
            else
              st_q <= ST_READ;
          end
        end
        ST_EXP:
          if (us_q >= cur_expo_q)
          begin
            st_q <= ST_READ;
          end
        ST_READ:
        begin
          frame_valid <= 1'b1;
          if (!line_open_q || line_end)
          begin
            if (line_open_q && (row_q == lines_q - 12'h001))
            begin
              line_valid  <= 1'b0;
              line_open_q <= 1'b0;
              st_q        <= ctrl_q[`DPS_C_FIXED] ? ST_PAD : ST_IDLE;
            end
            else
            begin
              // open next line and issue its strobes
              line_open_q <= 1'b1;
              line_valid  <= 1'b1;
              tick_q      <= 16'h0000;
              cyc_q       <= 10'h000;
              row_rd_stb  <= 1'b1;
              row_rd_idx  <= line_open_q ? row_q + 12'h001 : 12'h000;
              if (line_open_q)
                row_q <= row_q + 12'h001;
              if (!shutter_global && (rst_row < lines_q))
              begin
                row_rst_stb <= 1'b1;
                row_rst_idx <= line_open_q ? rst_row + 12'h001 : rst_row;
              end
            end
          end
        end
        ST_PAD:
        begin
          frame_valid <= 1'b0;
          if ((us_q >= cur_per_q) || (us_q >= FMAX[19:0]))
            st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

endmodule // dps_top

// ---- hdl/dps_regs.vh ----
// How it works
// - two profiles, each with own settings
// - manual, automatic or triggered profile choice
// - auto mode: M first, N second, repeat
// - M and N programmable up to 256
// - single mode: one frame per trigger
// - burst: wait trigger, M then N frames
// - insert: stream first, trigger inserts N second
// - global shutter: reset all, expose, read
// - rolling shutter: staggered per-line reset
// - 12-bit or 10-bit conversion, 12 slower
// - minimum line time from taps and row length
// - programmed line time may exceed minimum
// - fixed frame period up to one second
// - one, two, four, eight, ten taps
// - eight, ten or twelve bit pixels
// - link pixel clock 85 MHz, grabber runs at 2.5 MHz
// - trigger on rising or falling edge
// - alternating modes use first profile line time
`ifndef DPS_REGS_VH
`define DPS_REGS_VH
// register byte offsets; profile block base is matched on paddr[7:5]
`define DPS_OFS_CTRL      8'h00
`define DPS_OFS_COUNTS    8'h04
`define DPS_OFS_ROWPIX    8'h08
`define DPS_OFS_LINES     8'h0C
`define DPS_OFS_STATUS    8'h10
`define DPS_PROF_BASE     3'h1
// profile word index within a profile block
`define DPS_PW_EXPO       2'd0
`define DPS_PW_PERIOD     2'd1
`define DPS_PW_LINE       2'd2
`define DPS_PW_MISC       2'd3
// control fields
`define DPS_C_RUN         0
`define DPS_C_AUTO        1
`define DPS_C_TRIG_EN     3
`define DPS_C_TMODE_LO    4
`define DPS_C_TMODE_HI    5
`define DPS_C_MSEL        6
`define DPS_C_GLOBAL      7
`define DPS_C_ADC12       8
`define DPS_C_FALL        9
`define DPS_C_FIXED       10
`define DPS_C_TAPS_LO     11
`define DPS_C_TAPS_HI     13
`define DPS_C_DEPTH_LO    14
`define DPS_C_DEPTH_HI    15
`define DPS_CTRL_W        16
// trigger modes
`define DPS_TM_SINGLE     2'd0
`define DPS_TM_BURST      2'd1
`define DPS_TM_INSERT     2'd2
// tap codes and depth codes
`define DPS_TAP1          3'd0
`define DPS_TAP2          3'd1
`define DPS_TAP4          3'd2
`define DPS_TAP8          3'd3
`define DPS_TAP10         3'd4
`define DPS_D8            2'd0
`define DPS_D10           2'd1
`define DPS_D12           2'd2
// reset values
`define DPS_RST_CTRL      16'h0000
`define DPS_RST_COUNTS    16'h0000
`define DPS_RST_ROWPIX    16'h0FA0
`define DPS_RST_LINES     12'h010
`define DPS_RST_PROF      32'h00000000
// timing
`define DPS_CLK_NS        50
`define DPS_US_NS         1000
`define DPS_US_CYC        ((`DPS_US_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`define DPS_ADC10_US      9
`define DPS_ADC12_US      20
`define DPS_FRAME_MAX_US  1000000
`define DPS_PIX_MHZ       85
`endif

// ---- hdl/dps_sync.v ----
`timescale 1ns/1ns
// three-stage pin synchroniser with agreement filter and edge pulses
module dps_sync
(
  input  wire clk,
  input  wire srst,
  input  wire ce,
  input  wire din,
  output reg  lvl_q,
  output reg  rise_q,
  output reg  fall_q
);

  reg s1_q;
  reg s2_q;
  reg s3_q;

  // chain; first stage feeds only the second
  always @(posedge clk)
  begin
    if (srst)
    begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      lvl_q  <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else if (ce)
    begin
      s1_q   <= din;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      rise_q <= (s2_q == s3_q) && s2_q && !lvl_q;
      fall_q <= (s2_q == s3_q) && !s2_q && lvl_q;
      if (s2_q == s3_q)
        lvl_q <= s2_q;
    end
  end

endmodule // dps_sync

// ---- sim/dps_props.sv ----
`timescale 1ns/1ns
// watches apb answers, frame profile hold and link settings
module dps_props
(
  input wire        clk,
  input wire        srst,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        frame_valid,
  input wire        frame_prof,
  input wire        glob_rst,
  input wire        row_rst_stb,
  input wire [31:0] prof_misc,
  input wire        shutter_global,
  input wire [2:0]  taps_code,
  input wire [1:0]  depth_code
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // answer after one wait state, for one cycle
  ready_wait_a: assert property (
    ce && psel && penable && !pready |=> pready) else $error("apb answer late");
  ready_pulse_a: assert property (
    pready |=> !pready) else $error("apb answer held");
  // refused reads give zero, far addresses refused
  err_zero_a: assert property (
    pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
  far_err_a: assert property (
    psel && penable && pready && paddr >= 8'h40 |-> pslverr) else $error("far address taken");
  // profile and its settings hold through a frame
  prof_hold_a: assert property (
    frame_valid && $past(frame_valid) |-> $stable(frame_prof) && $stable(prof_misc))
    else $error("profile changed in frame");
  // tap and depth pair stays within link bandwidth
  link_legal_a: assert property (
    taps_code <= 3'h4 && depth_code <= 2'h2 && !(taps_code == 3'h3 && depth_code == 2'h2)
    && !(taps_code == 3'h4 && depth_code != 2'h0)) else $error("illegal tap depth pair");
  // global reset only ahead of readout, one cycle
  glob_idle_a: assert property (
    glob_rst |-> (shutter_global && !frame_valid) ##1 !glob_rst) else $error("bad global reset");
  row_roll_a: assert property (
    row_rst_stb |-> !shutter_global) else $error("row reset in global mode");
endmodule // dps_props

bind dps_top dps_props dps_props_i
(
  .clk, .srst, .ce, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr,
  .frame_valid, .frame_prof, .glob_rst, .row_rst_stb, .prof_misc, .shutter_global,
  .taps_code, .depth_code
);

// ---- sim/dps_grabber.sv ----
`timescale 1ns/1ns
// grabber side: pixel clock that stands still between frames
module dps_grabber
(
  input  wire  frame_valid,
  output logic lnk_clk
);
  // 400 ns period, edges land on system clock falling edges
  initial lnk_clk = 1'b0;
  always #200 lnk_clk = frame_valid ? ~lnk_clk : 1'b0;
endmodule // dps_grabber

// ---- sim/dps_top_tb_top.sv ----
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, a, b); end end
// sequencer bench
module dps_top_tb_top;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        trig_in = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rdat;
  logic        rerr;
  int          errors = 0;
  int          samples_checked = 0;
  wire         pready, pslverr, lnk_clk, frame_valid, line_valid, frame_prof;
  wire         glob_rst, row_rst_stb, adc12, shutter_global;
  wire [31:0]  prdata, prof_misc;
  wire [2:0]   taps_code;
  wire [1:0]   depth_code;
  dps_top dps_top_i
  (
    .clk, .srst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .trig_in, .lnk_clk, .frame_valid, .line_valid, .frame_prof, .glob_rst,
    .row_rst_stb, .row_rst_idx(), .row_rd_stb(), .row_rd_idx(), .prof_misc, .adc12,
    .shutter_global, .taps_code, .depth_code
  );
  dps_grabber dps_grabber_i (.frame_valid, .lnk_clk);
  // 50 ns system clock
  initial forever #25 clk = ~clk;
  task automatic end_of_test;
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic fail;
    errors++;
    end_of_test;
  endtask
  // one apb transfer, answer left in rdat and rerr
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    // look between edges, then take the answer at the edge that samples it
    @(negedge clk);
    while (pready !== 1'b1)
    begin
      @(negedge clk);
      t++;
      if (t > 40)
        fail;
    end
    @(posedge clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic er);
    xfer(1'b0, a, 32'h0);
    `CHK(rdat, e)
    `CHK(rerr, er)
  endtask
  // bounded wait for frame_valid to reach v
  task automatic wt(input logic v);
    int t;
    t = 0;
    while (frame_valid !== v)
    begin
      @(posedge clk);
      t++;
      if (t > 20000)
        fail;
    end
  endtask
  // next n frames carry profiles s[0], s[1] ...
  task automatic see(input int n, input logic [3:0] s);
    for (int i = 0; i < n; i++)
    begin
      wt(1'b0);
      wt(1'b1);
      `CHK(frame_prof, s[i])
      `CHK(prof_misc, s[i] ? 32'h00000022 : 32'h00000011)
    end
  endtask
  // no frame starts for n cycles
  task automatic quiet(input int n);
    wt(1'b0);
    repeat (n)
    begin
      @(posedge clk);
      `CHK(frame_valid, 1'b0)
    end
  endtask
  task automatic trig(input logic v);
    trig_in <= v;
    @(posedge clk);
  endtask
  task automatic t_regs;
    rc(8'h08, 32'h00000FA0, 1'b0);
    rc(8'h0C, 32'h00000010, 1'b0);
    rc(8'h3C, 32'h0, 1'b0);
    rc(8'h40, 32'h0, 1'b1);
    xfer(1'b1, 8'h14, 32'h0000FFFF);
    `CHK(rerr, 1'b1)
  endtask
  // every tap and depth code, legal pairs then refused ones
  task automatic t_link;
    logic [5:0] cfg [9] = '{6'h00, 6'h09, 6'h12, 6'h0B, 6'h04, 6'h33, 6'h2C, 6'h25, 6'h38};
    logic [4:0] keep = 5'h00;
    foreach (cfg[k])
    begin
      xfer(1'b1, 8'h00, {16'h0, cfg[k][4:0], 11'h180});
      `CHK(rerr, cfg[k][5])
      if (!cfg[k][5])
        keep = cfg[k][4:0];
      `CHK({depth_code, taps_code}, keep)
      xfer(1'b0, 8'h10, 32'h0);
      `CHK(rdat[4], cfg[k][5])
    end
    `CHK({adc12, shutter_global}, 2'b11)
  endtask
  // short frames, two first then one second, global shutter
  task automatic t_auto;
    logic [39:0] w [7] = '{40'h08_00000008, 40'h0C_00000002, 40'h20_00000001,
      40'h2C_00000011, 40'h30_00000001, 40'h3C_00000022, 40'h04_00000001};
    foreach (w[k])
      xfer(1'b1, w[k][39:32], w[k][31:0]);
    xfer(1'b1, 8'h00, 32'h00000083);
    see(4, 4'b0100);
    xfer(1'b1, 8'h00, 32'h0);
    wt(1'b0);
  endtask
  // manual choice, changed in mid-frame, rolling shutter
  task automatic t_manual;
    xfer(1'b1, 8'h00, 32'h00000041);
    see(2, 4'b0011);
    xfer(1'b1, 8'h00, 32'h00000001);
    see(2, 4'b0000);
    xfer(1'b1, 8'h00, 32'h0);
    wt(1'b0);
  endtask
  // burst on falling edge, then single frame on rising edge
  task automatic t_trig;
    xfer(1'b1, 8'h04, 32'h0);
    xfer(1'b1, 8'h00, 32'h00000219);
    trig(1'b1);
    quiet(300);
    trig(1'b0);
    see(2, 4'b0010);
    quiet(600);
    xfer(1'b1, 8'h00, 32'h00000049);
    trig(1'b1);
    see(1, 4'b0001);
    quiet(600);
  endtask
  // reset, then the scenarios
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_link;
    t_auto;
    t_manual;
    t_trig;
    end_of_test;
  end
endmodule // dps_top_tb_top
